/* File: sarseq_top.sv */
// Purpose: Sequencer of a 16-bit charge redistribution SAR converter.
// Assumes: Comparator and range flags are asynchronous analog outputs.
// Notes: Host pins and a mirrored control register both drive it.
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module sarseq_top (
	// APB slave.
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Host pins.
	input wire logic conversion_start_n,
	input wire logic output_coding_select,
	input wire logic reset_request,
	input wire logic power_down_request,
	// Analog side inputs.
	input wire logic comparator_high,
	input wire logic over_range,
	input wire logic input_ground_sense,
	// Analog side outputs.
	output sarseq_pkg::sarseq_sw_t switches,
	output logic busy,
	output logic [15:0] result,
	output logic irq
);
	// Synchroniser stages for pins; first stages are read only by second.
	logic [6:0] sync1_r;
	logic [6:0] sync2_r;
	logic start_prev_r;
	// Register file.
	logic [3:0] ctrl_r;
	logic [1:0] irq_stat_r;
	logic [1:0] irq_mask_r;
	// Sequencer state.
	sarseq_pkg::sarseq_state_t state_r;
	logic [3:0] div_r;
	logic [3:0] settle_r;
	logic [3:0] idx_r;
	logic [15:0] trial_r;
	logic clamp_r;
	logic [15:0] clamp_code_r;
	// Decoded pin levels after synchronisation.
	logic start_n_s, coding_s, reset_s, pd_s, comp_s, over_s, under_s;
	logic cclk_en, start_fall, abort, coding, done_evt, clamp_evt;
	logic apb_wr, apb_rd_ack;
	assign start_n_s = sync2_r[0];
	assign coding_s = sync2_r[1];
	assign reset_s = sync2_r[2];
	assign pd_s = sync2_r[3];
	assign comp_s = sync2_r[4];
	assign over_s = sync2_r[5];
	assign under_s = sync2_r[6];
	// Pin or software request; software start bit acts as a pulse.
	assign abort = reset_s | ctrl_r[sarseq_pkg::CTRL_RESET];
	assign coding = coding_s | ctrl_r[sarseq_pkg::CTRL_CODING];
	assign start_fall = (start_prev_r & ~start_n_s)
		| ctrl_r[sarseq_pkg::CTRL_START];
	assign cclk_en = (div_r == sarseq_pkg::CCLK_DIV);
	assign apb_wr = psel & penable & pwrite;
	assign apb_rd_ack = psel & penable & ~pwrite;
	assign done_evt = (state_r == sarseq_pkg::SQ_ASSEMBLE) & cclk_en;
	assign clamp_evt = done_evt & clamp_r;

	// Two-stage synchroniser for every asynchronous input.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// Both stages reset to the idle start level, so the edge
			// detector sees no false falling edge after reset.
			sync1_r <= 7'h01;
			sync2_r <= 7'h01;
			start_prev_r <= 1'b1;
		end else begin
			sync1_r <= {input_ground_sense, over_range, comparator_high,
				power_down_request, reset_request,
				output_coding_select, conversion_start_n};
			sync2_r <= sync1_r;
			start_prev_r <= start_n_s;
		end
	end

	// Divider producing the internal conversion clock enable.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_r <= 4'h0;
		end else if (cclk_en || state_r == sarseq_pkg::SQ_ACQ) begin
			div_r <= 4'h0;
		end else begin
			div_r <= div_r + 4'h1;
		end
	end

	// Main sequencer: acquisition, hold, binary search, assembly.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= sarseq_pkg::SQ_ACQ;
			settle_r <= 4'h0;
			idx_r <= 4'h0;
			trial_r <= 16'h0000;
			clamp_r <= 1'b0;
			clamp_code_r <= 16'h0000;
		end else if (abort) begin
			// Abort returns to acquisition with the search discarded.
			state_r <= sarseq_pkg::SQ_ACQ;
			settle_r <= 4'h0;
			trial_r <= 16'h0000;
			clamp_r <= 1'b0;
		end else begin
			case (state_r)
				sarseq_pkg::SQ_ACQ: begin
					// Power-down blocks new starts only from here.
					if (start_fall && !pd_s) begin
						state_r <= sarseq_pkg::SQ_OPEN_GND;
						settle_r <= 4'h0;
					end
				end
				sarseq_pkg::SQ_OPEN_GND: begin
					if (cclk_en) begin
						if (settle_r == sarseq_pkg::SETTLE_CNT) begin
							state_r <= sarseq_pkg::SQ_HOLD;
							settle_r <= 4'h0;
						end else begin
							settle_r <= settle_r + 4'h1;
						end
					end
				end
				sarseq_pkg::SQ_HOLD: begin
					// Range is judged on the held sample.
					if (cclk_en) begin
						state_r <= sarseq_pkg::SQ_SEARCH;
						idx_r <= sarseq_pkg::IDX_MSB;
						trial_r <= sarseq_pkg::TWOS_FLIP;
						clamp_r <= over_s | under_s;
						clamp_code_r <= over_s ? sarseq_pkg::CODE_FULL
							: sarseq_pkg::CODE_ZERO;
					end
				end
				sarseq_pkg::SQ_SEARCH: begin
					if (cclk_en) begin
						// Comparator high means trial is too large.
						trial_r[idx_r] <= ~comp_s;
						if (idx_r == 4'h0) begin
							state_r <= sarseq_pkg::SQ_ASSEMBLE;
						end else begin
							trial_r[idx_r - 4'h1] <= 1'b1;
							idx_r <= idx_r - 4'h1;
						end
					end
				end
				sarseq_pkg::SQ_ASSEMBLE: begin
					if (cclk_en) begin
						state_r <= sarseq_pkg::SQ_DONE;
					end
				end
				sarseq_pkg::SQ_DONE: begin
					state_r <= sarseq_pkg::SQ_ACQ;
				end
				default: begin
					state_r <= sarseq_pkg::SQ_ACQ;
				end
			endcase
		end
	end

	// Result latch: written once per conversion from that sample only.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result <= 16'h0000;
		end else if (done_evt && !abort) begin
			// Straight binary, top bit flipped in two's complement mode.
			result <= (clamp_r ? clamp_code_r : trial_r)
				^ (coding ? 16'h0000 : sarseq_pkg::TWOS_FLIP);
		end
	end

	// Busy output from the state, low again in the cycle after latching.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy <= 1'b0;
		end else begin
			busy <= !abort && state_r != sarseq_pkg::SQ_ACQ
				&& state_r != sarseq_pkg::SQ_DONE;
		end
	end

	// Switch drive; acquisition grounds the common node.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			switches <= '{1'b1, 1'b1, 1'b1, 16'h0000};
		end else begin
			case (state_r)
				sarseq_pkg::SQ_ACQ: begin
					switches <= '{1'b1, 1'b1, 1'b1, 16'h0000};
				end
				sarseq_pkg::SQ_OPEN_GND: begin
					switches <= '{1'b0, 1'b0, 1'b1, 16'h0000};
				end
				sarseq_pkg::SQ_HOLD: begin
					switches <= '{1'b0, 1'b0, 1'b0, 16'h0000};
				end
				default: begin
					switches <= '{1'b0, 1'b0, 1'b0, trial_r};
				end
			endcase
		end
	end

	// Control register; start and reset bits self-clear.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= 4'h0;
		end else if (apb_wr && paddr == sarseq_pkg::OFF_CTRL) begin
			ctrl_r <= pwdata[3:0];
		end else begin
			ctrl_r[sarseq_pkg::CTRL_START] <= 1'b0;
			ctrl_r[sarseq_pkg::CTRL_RESET] <= 1'b0;
		end
	end

	// Sticky interrupt status, write one to clear; set wins.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_r <= 2'h0;
			irq_mask_r <= 2'h0;
		end else begin
			if (apb_wr && paddr == sarseq_pkg::OFF_MASK) begin
				irq_mask_r <= pwdata[1:0];
			end
			irq_stat_r <= (irq_stat_r
				& ~((apb_wr && paddr == sarseq_pkg::OFF_IRQ)
				? pwdata[1:0] : 2'h0))
				| {clamp_evt && !abort, done_evt && !abort};
		end
	end

	// Interrupt output registered from masked status.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat_r & irq_mask_r);
		end
	end

	// APB read data and answer; zero wait states, unmapped errors.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & ~penable;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
			if (psel && !penable) begin
				case (paddr)
					sarseq_pkg::OFF_CTRL: prdata <= {28'h0, ctrl_r};
					sarseq_pkg::OFF_STAT: prdata <= {28'h0, pd_s,
						reset_s, clamp_r, busy};
					sarseq_pkg::OFF_DATA: prdata <= {16'h0000, result};
					sarseq_pkg::OFF_IRQ: prdata <= {30'h0, irq_stat_r};
					sarseq_pkg::OFF_MASK: prdata <= {30'h0, irq_mask_r};
					default: pslverr <= 1'b1;
				endcase
			end
		end
	end
endmodule

/* File: sarseq_pkg.sv */
// Purpose: Shared constants and types for the SAR conversion sequencer.
// Assumes: One 50 MHz clock; APB register access with 32-bit data.
// Notes: Register offsets are byte addresses of aligned words.
package sarseq_pkg;
	// Word width of a conversion result.
	localparam int unsigned RES_W = 16;
	// Width of the bit index counter.
	localparam int unsigned IDX_W = 4;
	// Index of the most significant element.
	localparam logic [3:0] IDX_MSB = 4'hf;
	// Divider terminal count for the internal conversion clock enable.
	localparam logic [3:0] CCLK_DIV = 4'h9;
	// Settle cycles of conversion clock between switch phases.
	localparam logic [3:0] SETTLE_CNT = 4'h1;
	// Full-scale and zero-scale straight binary codes.
	localparam logic [15:0] CODE_FULL = 16'hffff;
	localparam logic [15:0] CODE_ZERO = 16'h0000;
	// Mask of the top bit, inverted for two's complement.
	localparam logic [15:0] TWOS_FLIP = 16'h8000;
	// Register byte offsets.
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STAT = 8'h04;
	localparam logic [7:0] OFF_DATA = 8'h08;
	localparam logic [7:0] OFF_IRQ = 8'h0c;
	localparam logic [7:0] OFF_MASK = 8'h10;
	// Control bit positions.
	localparam int unsigned CTRL_START = 0;
	localparam int unsigned CTRL_CODING = 1;
	localparam int unsigned CTRL_RESET = 2;
	localparam int unsigned CTRL_PD = 3;
	// Interrupt bit positions.
	localparam int unsigned IRQ_DONE = 0;
	localparam int unsigned IRQ_CLAMP = 1;
	localparam int unsigned IRQ_W = 2;
	// Sequencer states.
	typedef enum logic [2:0] {
		SQ_ACQ, SQ_OPEN_GND, SQ_HOLD, SQ_SEARCH, SQ_ASSEMBLE, SQ_DONE
	} sarseq_state_t;
	// Switch drive bundle towards the analog array.
	typedef struct packed {
		logic array_ground_switch;
		logic dummy_ground_switch;
		logic inputs_connected;
		logic [15:0] element_to_ref;
	} sarseq_sw_t;
endpackage

/* File: sarseq_checker.sv */
// Purpose: Port-level assertions for the conversion sequencer.
// Assumes: One clock domain with an active-low asynchronous reset.
// Notes: Attached to the top module by the bind at the foot.
`timescale 1ns/1ps
module sarseq_checker (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Host pins.
	input wire logic conversion_start_n,
	input wire logic reset_request,
	input wire logic power_down_request,
	// Sequencer outputs.
	input wire sarseq_pkg::sarseq_sw_t switches,
	input wire logic busy,
	input wire logic [15:0] result
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Busy frame length: twenty conversion clock ticks of ten pclk each.
	localparam int CONV_CYCLES = (int'(sarseq_pkg::SETTLE_CNT) + 3
		+ sarseq_pkg::RES_W) * (int'(sarseq_pkg::CCLK_DIV) + 1);
	logic [15:0] busy_cnt_r; // Cycles that busy has stood high.
	// Counts the cycles of one busy frame, cleared while idle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_cnt_r <= 16'h0000;
		end else if (busy) begin
			busy_cnt_r <= busy_cnt_r + 16'h0001;
		end else begin
			busy_cnt_r <= 16'h0000;
		end
	end
	// An idle start edge that nothing blocks.
	sequence start_seen;
		$fell(conversion_start_n) && !busy && !reset_request &&
			!power_down_request;
	endsequence
	// The sampled level has left the array inputs.
	sequence hold_begins;
		$fell(switches.inputs_connected);
	endsequence
	chk_acq_ground: assert property (switches.array_ground_switch |->
		switches.inputs_connected && switches.dummy_ground_switch &&
		switches.element_to_ref == 16'h0)
		else $error("acquire switch state wrong");
	chk_ground_first: assert property (hold_begins |->
		$past(!switches.array_ground_switch && !switches.dummy_ground_switch))
		else $error("ground switches not opened first");
	chk_hold_ref: assert property (hold_begins |->
		switches.element_to_ref == 16'h0 && !switches.dummy_ground_switch)
		else $error("hold not on reference ground");
	chk_start_busy: assert property (start_seen |-> ##[1:6] busy)
		else $error("busy did not follow start");
	chk_msb_first: assert property ($rose(|switches.element_to_ref) |->
		switches.element_to_ref == 16'h8000)
		else $error("search did not begin at top element");
	chk_conv_length: assert property ($rose(busy) && !reset_request |->
		busy[*8] ##[1:400] !busy)
		else $error("conversion length out of range");
	chk_conv_exact: assert property ($fell(busy) && !reset_request &&
		!$past(reset_request) |-> busy_cnt_r == CONV_CYCLES)
		else $error("conversion cycle count wrong");
	chk_reset_abort: assert property (reset_request |-> ##[1:4] !busy)
		else $error("reset did not abort");
	chk_result_hold: assert property (!busy && $past(!busy) &&
		!reset_request && !$past(reset_request) |-> $stable(result))
		else $error("result changed while idle");
endmodule
bind sarseq_top sarseq_checker chk (.pclk(pclk), .presetn(presetn),
	.conversion_start_n(conversion_start_n), .reset_request(reset_request),
	.power_down_request(power_down_request), .switches(switches),
	.busy(busy), .result(result));

/* File: sarseq_array_model.sv */
// Purpose: Behavioural capacitor array and comparator.
// Assumes: The level to convert is a 16-bit code.
// Notes: A perfect array, so the search returns the held level.
`timescale 1ns/1ps
module sarseq_array_model (
	// Clock and switch drive.
	input wire logic pclk,
	input wire sarseq_pkg::sarseq_sw_t switches,
	// Level presented at the input.
	input wire logic [15:0] vin,
	// Comparator decision.
	output logic comparator_high
);
	logic [15:0] held; // Level held on the array.
	// The array tracks the input while connected and holds it after.
	always_ff @(posedge pclk) begin
		if (switches.inputs_connected) begin
			held <= vin;
		end
	end
	// The comparator tips when the trial code is above the held level.
	assign comparator_high = switches.element_to_ref > held;
endmodule

/* File: sarseq_bench.sv */
// Purpose: Self-checking bench for the conversion sequencer.
// Assumes: Inputs change just after rising edges.
// Notes: Levels come from a shift register with a fixed seed.
`timescale 1ns/1ps
module sarseq_bench;
	// Bus, pin and model signals.
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd, sd = 32'h19d9;
	logic pready, pslverr, start_n = 1, cod = 1, rst_req = 0, pd = 0;
	logic ovr = 0, und = 0, cmp_hi, busy, irq, serr;
	logic [15:0] vin = 16'h0, result;
	sarseq_pkg::sarseq_sw_t switches;
	int error_cnt = 0, n_compared = 0;
	sarseq_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .conversion_start_n(start_n),
		.output_coding_select(cod), .reset_request(rst_req),
		.power_down_request(pd), .comparator_high(cmp_hi),
		.over_range(ovr), .input_ground_sense(und),
		.switches(switches), .busy(busy), .result(result), .irq(irq));
	sarseq_array_model model (.pclk(pclk), .switches(switches),
		.vin(vin), .comparator_high(cmp_hi));
	// The clock toggles every half period.
	initial begin
		forever #10 pclk = ~pclk;
	end
	// Next value of the stimulus shift register.
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	// Expected code for a level, coding and range flags.
	function automatic logic [31:0] expv(input logic [15:0] v,
		input logic c, o, u);
		logic [15:0] w;
		w = u ? 16'h0000 : (o ? 16'hffff : v);
		return {16'h0000, c ? w : w ^ 16'h8000};
	endfunction
	// Prints the verdict and ends the run.
	task automatic wrap_up();
		if (error_cnt == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// Compares one value and counts it.
	task automatic cmp(input logic [31:0] got, exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Waits for busy to reach a level, within a bound.
	task automatic wait_lvl(input logic b);
		int n;
		n = 0;
		while (busy !== b && n < 2000) begin
			@(negedge pclk);
			n++;
		end
		if (busy !== b) begin
			cmp({31'h0, busy}, {31'h0, b});
			wrap_up();
		end
	endtask
	// One APB transfer; read data lands in rd, the error flag in serr.
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		// Access phase: pready is taken as it stands at each rising edge.
		@(posedge pclk);
		while (pready !== 1'b1 && n < 50) begin
			@(posedge pclk);
			n++;
		end
		if (pready !== 1'b1) begin
			cmp(32'h0, 32'h1);
			wrap_up();
		end
		rd = prdata;
		serr = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// Starts one conversion from the pin and checks its word.
	task automatic conv(input logic [15:0] v, input logic c, o, u);
		@(posedge pclk);
		vin <= v;
		cod <= c;
		ovr <= o;
		und <= u;
		start_n <= 0;
		wait_lvl(1);
		@(posedge pclk);
		start_n <= 1;
		wait_lvl(0);
		cmp({16'h0, result}, expv(v, c, o, u));
		apb(0, sarseq_pkg::OFF_DATA, 32'h0);
		cmp({16'h0, rd[15:0]}, expv(v, c, o, u));
	endtask
	// Main sequence.
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1;
		cmp({13'h0, switches}, 32'h70000);
		apb(1, sarseq_pkg::OFF_MASK, 32'h0);
		// Midscale in both codings, clamps, then random levels.
		for (int i = 0; i < 14; i++) begin
			sd = lfsr(sd);
			conv(i < 2 ? 16'h8000 : sd[15:0], i < 6 ? i[0] : sd[16],
				i inside {2, 3}, i inside {4, 5});
		end
		repeat (2) @(negedge pclk);
		cmp({31'h0, irq}, 32'h0);
		apb(1, sarseq_pkg::OFF_MASK, 32'h3);
		repeat (2) @(negedge pclk);
		cmp({31'h0, irq}, 32'h1);
		apb(1, sarseq_pkg::OFF_IRQ, 32'h3);
		repeat (2) @(negedge pclk);
		cmp({31'h0, irq}, 32'h0);
		apb(1, sarseq_pkg::OFF_MASK, 32'h0);
		apb(0, 8'h20, 32'h0);
		cmp({31'h0, serr}, 32'h1);
		// Abort a conversion early in the search, during its top-bit trial.
		@(posedge pclk);
		start_n <= 0;
		wait_lvl(1);
		repeat (30) @(posedge pclk);
		rst_req <= 1;
		start_n <= 1;
		repeat (5) @(negedge pclk);
		cmp({31'h0, busy}, 32'h0);
		cmp({13'h0, switches}, 32'h70000);
		@(posedge pclk);
		rst_req <= 0;
		// Power-down lets the running conversion end, then blocks.
		@(posedge pclk);
		start_n <= 0;
		wait_lvl(1);
		@(posedge pclk);
		pd <= 1;
		start_n <= 1;
		wait_lvl(0);
		@(posedge pclk);
		start_n <= 0;
		repeat (20) @(negedge pclk);
		cmp({31'h0, busy}, 32'h0);
		// A register start in straight binary.
		@(posedge pclk);
		pd <= 0;
		start_n <= 1;
		cod <= 1;
		ovr <= 0;
		und <= 0;
		apb(1, sarseq_pkg::OFF_CTRL, 32'h1);
		wait_lvl(1);
		wait_lvl(0);
		cmp({16'h0, result}, expv(vin, 1'b1, 1'b0, 1'b0));
		wrap_up();
	end
endmodule
